//--- logic/lpm_pkg.sv
//------------------------------------------------------------
// Purpose: Shared constants for the low-power mode controller
// Assumes: 32-bit classic Wishbone, one byte of data per register
// Notes:   Crystal clock runs at the ref_clk rate
//------------------------------------------------------------
package lpm_pkg;

  // ----------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] PLL_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0C;

  // Configuration fields
  localparam int CFG_OSC_RUN = 0;
  localparam int CFG_STOP_EN = 1;
  localparam int CFG_SHORT_REC = 2;
  localparam int CFG_LVM_EN = 3;
  localparam int CFG_LVM_RST_EN = 4;
  localparam int CFG_BRK_EN = 5;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // PLL control fields
  localparam int PLL_BCS = 0;
  localparam int PLL_ON = 1;
  localparam logic [7:0] PLL_RESET = 8'h00;

  // Mask fields: masks set, processor mask bit set
  localparam int MSK_EXT = 0;
  localparam int MSK_KBD = 1;
  localparam int MSK_CPU_I = 2;
  localparam logic [7:0] MASK_RESET = 8'h07;

  // Status fields
  localparam int ST_MODE = 0;
  localparam int ST_BRK_FLAG = 2;
  localparam int ST_RST_WAKE = 3;
  localparam int ST_RECOV = 4;

  // Recovery timing in crystal cycles
  localparam int XTAL_PER_REF = 1;
  localparam int RECOV_LONG_XTAL = 4096;
  localparam int RECOV_SHORT_XTAL = 32;
  localparam int RECOV_LONG_CYC = RECOV_LONG_XTAL * XTAL_PER_REF;
  localparam int RECOV_SHORT_CYC = RECOV_SHORT_XTAL * XTAL_PER_REF;

  // Operating modes
  typedef enum logic [1:0] {M_RUN, M_STANDBY, M_DEEP, M_RECOVER} lp_mode_t;

endpackage

//--- logic/lp_recov_if.sv
//------------------------------------------------------------
// Purpose: Link between the mode sequencer and recovery timer
// Assumes: One clock domain
// Notes:   start is a one-cycle pulse
//------------------------------------------------------------
`timescale 1ns/1ps
interface lp_recov_if;
  logic start;
  logic shortSel;
  logic busy;
  modport ctrl (output start, output shortSel, input busy);
  modport tmr (input start, input shortSel, output busy);
endinterface

//--- logic/recov_timer.sv
//------------------------------------------------------------
// Purpose: Holds system clocks off after leaving deep mode
// Assumes: Crystal cycles equal ref_clk cycles
// Notes:   busy stays high for exactly the chosen cycle count
//------------------------------------------------------------
`timescale 1ns/1ps
module recov_timer import lpm_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Sequencer side
  lp_recov_if.tmr rec
);

  logic [11:0] cnt_r;

  // Load on start, count down, release at zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_r <= 12'h000;
      rec.busy <= 1'b0;
    end else if (rec.start) begin
      cnt_r <= rec.shortSel ? 12'(RECOV_SHORT_CYC - 1) : 12'(RECOV_LONG_CYC - 1);
      rec.busy <= 1'b1;
    end else if (rec.busy) begin
      if (cnt_r == 12'h000) begin
        rec.busy <= 1'b0;
      end else begin
        cnt_r <= cnt_r - 12'h001;
      end
    end
  end

endmodule // recov_timer

//--- logic/pin_sync3.sv
//------------------------------------------------------------
// Purpose: Three-stage synchroniser for asynchronous pins
// Assumes: Inputs are slow levels
// Notes:   Output moves only when stages two and three agree
//------------------------------------------------------------
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Pins in, clean levels out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] s1_r, s2_r, s3_r;

  // One chain per pin
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        s1_r[i] <= 1'b0;
        s2_r[i] <= 1'b0;
        s3_r[i] <= 1'b0;
        dout[i] <= 1'b0;
      end else begin
        s1_r[i] <= din[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] == s3_r[i]) begin
          dout[i] <= s3_r[i];
        end
      end
    end
  end

endmodule // pin_sync3

//--- logic/lp_mode_ctrl.sv
//------------------------------------------------------------
// Purpose: Standby and deep low-power mode controller
// Assumes: Interrupt inputs from peripherals are already enabled
// Notes:   Outputs are registered from the next mode
//------------------------------------------------------------
// Operation
// (R1) Standby stops processor clock, bus clock keeps running
// (R2) Deep stops processor clock; bus clock too unless oscillator runs
// (R3) Converter runs in standby, its interrupt wakes the core
// (R4) Deep mode stops converter and aborts conversion
// (R5) Enabled breakpoint unit stays active in standby
// (R6) Breakpoint idle in deep; break wakes and sets the flag
// (R7) Wait clears mask bit; interrupt wake keeps it, reset sets it
// (R8) Stop clears mask bit; interrupt wake keeps it, reset sets it
// (R9) Processor clock held off after deep until oscillator settles
// (R10) Clock generator active in standby; software owns PLL bits
// (R11) Deep without oscillator run: oscillator, PLL, outputs off
// (R12) Deep entry clears base clock select; stays clear after
// (R13) Deep with oscillator run: PLL off, oscillator on
// (R14) Watchdog counts in standby; software services it
// (R15) Deep removes watchdog clock and clears its prescaler
// (R16) Stop enters deep only when stop enable is set
// (R17) External interrupt wakes either mode when unmasked
// (R18) Keypad interrupt wakes either mode when unmasked
// (R19) Enabled voltage monitor active; its reset ends either mode
// (R20) Async serial runs in standby, halts in deep, cut transfer bad
// (R21) Sync serial halts in deep; reset exit resets it
// (R22) Timers run in standby, halt in deep keeping state
// (R23) Deep exit holds clocks 4096 cycles, or 32 if short
// (R24) One wake request from all sources, reset first
`timescale 1ns/1ps
module lp_mode_ctrl import lpm_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Processor
  input wire logic waitExec,
  input wire logic stopExec,
  output logic cpuClkEn,
  output logic busClkEn,
  output logic irqMaskBit,
  // Pins
  input wire logic extIrqPin,
  input wire logic kbdIrqPin,
  input wire logic lowVoltPin,
  input wire logic extRstPin,
  // Peripheral requests
  input wire logic converterIrq,
  input wire logic asyncSerialIrq,
  input wire logic syncSerialIrq,
  input wire logic timerIrq,
  input wire logic generatorIrq,
  input wire logic breakMatch,
  input wire logic watchdogTimeout,
  input wire logic asyncSerialBusy,
  // Clock generator
  output logic oscEnable,
  output logic pllEnable,
  output logic genOutputsEn,
  output logic baseClockSelect,
  // Peripheral control
  output logic converterRun,
  output logic converterAbort,
  output logic breakActive,
  output logic watchdogClkEn,
  output logic watchdogPrescClr,
  output logic lowVoltActive,
  output logic periphRun,
  output logic asyncDataBad,
  output logic syncSerialReset,
  // Wake report
  output logic wakeReq,
  output logic wakeByReset
);

  // ----------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------
  lp_mode_t state_r, state_nxt;
  logic [7:0] cfg_r, pll_r, mask_r;
  logic brkFlag_r, rstCause_r;
  logic [3:0] pinLvl;
  logic extIrqS, kbdIrqS, lowVoltS, extRstS;
  logic busReq, busWr;
  logic oscRun, stopEn, shortRec, lvmEn, lvmRstEn, brkEn;
  logic resetWake, extWake, brkWake, idleWake, deepWake;
  logic enterStandby, enterDeep, inLowPower, lvmRst;
  logic [12:0] recCnt_r;

  lp_recov_if rec();

  // Register address match, used for read and write
  function automatic logic isReg(input logic [7:0] adr, input logic [7:0] ofs);
    return adr == ofs;
  endfunction

  // ----------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------
  // Pin synchronisers
  pin_sync3 #(.W(4)) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .din({extRstPin, lowVoltPin, kbdIrqPin, extIrqPin}),
    .dout(pinLvl)
  );
  assign extIrqS = pinLvl[0];
  assign kbdIrqS = pinLvl[1];
  assign lowVoltS = pinLvl[2];
  assign extRstS = pinLvl[3];

  // Recovery timer
  recov_timer u_recov (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .rec(rec.tmr)
  );

  // ----------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------
  assign oscRun = cfg_r[CFG_OSC_RUN];
  assign stopEn = cfg_r[CFG_STOP_EN];
  assign shortRec = cfg_r[CFG_SHORT_REC];
  assign lvmEn = cfg_r[CFG_LVM_EN];
  assign lvmRstEn = cfg_r[CFG_LVM_RST_EN];
  assign brkEn = cfg_r[CFG_BRK_EN];

  // ----------------------------------------------------------
  // Wake sources
  // ----------------------------------------------------------
  // Resets outrank every interrupt wake
  assign lvmRst = lvmEn & lvmRstEn & lowVoltS; // see (R19)
  assign resetWake = extRstS | watchdogTimeout | lvmRst; // see (R24)
  assign extWake = (~mask_r[MSK_EXT] & extIrqS) // see (R17)
    | (~mask_r[MSK_KBD] & kbdIrqS); // see (R18)
  assign brkWake = brkEn & breakMatch; // see (R5)
  // Standby: every enabled peripheral request wakes
  assign idleWake = extWake | brkWake | converterIrq // see (R3)
    | asyncSerialIrq | syncSerialIrq | timerIrq // see (R20) see (R21) see (R22)
    | (generatorIrq & pll_r[PLL_ON]); // see (R10)
  // Deep: only external, keypad and break remain
  assign deepWake = extWake | brkWake; // see (R6)

  // ----------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------
  assign enterStandby = (state_r == M_RUN) & waitExec;
  assign enterDeep = (state_r == M_RUN) & ~waitExec & stopExec & stopEn; // see (R16)
  assign inLowPower = (state_r == M_STANDBY) | (state_r == M_DEEP);

  // Next mode
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      M_RUN: begin
        if (enterStandby) begin
          state_nxt = M_STANDBY;
        end else if (enterDeep) begin
          state_nxt = M_DEEP;
        end
      end
      M_STANDBY: begin
        if (resetWake | idleWake) begin
          state_nxt = M_RUN; // see (R24)
        end
      end
      M_DEEP: begin
        if (resetWake | deepWake) begin
          state_nxt = M_RECOVER; // see (R24)
        end
      end
      M_RECOVER: begin
        if (!rec.busy) begin
          state_nxt = M_RUN; // see (R9) see (R23)
        end
      end
    endcase
  end

  // Mode register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r <= M_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Start the recovery count on leaving deep mode
  assign rec.start = (state_r == M_DEEP) & (state_nxt == M_RECOVER); // see (R23)
  assign rec.shortSel = shortRec;

  // ----------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------
  assign busReq = wb_cyc_i & wb_stb_i;
  assign busWr = busReq & wb_we_i & wb_ack_o & wb_sel_i[0];

  // Acknowledge one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= busReq & ~wb_ack_o;
    end
  end

  // Read data, zero for unmapped addresses
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (busReq & ~wb_ack_o) begin
      wb_dat_o <= 32'h0000_0000;
      if (isReg(wb_adr_i, CFG_OFS)) begin
        wb_dat_o[7:0] <= cfg_r;
      end
      if (isReg(wb_adr_i, PLL_OFS)) begin
        wb_dat_o[7:0] <= pll_r;
      end
      if (isReg(wb_adr_i, MASK_OFS)) begin
        wb_dat_o[7:0] <= mask_r;
      end
      if (isReg(wb_adr_i, STAT_OFS)) begin
        wb_dat_o[ST_MODE+1:ST_MODE] <= state_r;
        wb_dat_o[ST_BRK_FLAG] <= brkFlag_r;
        wb_dat_o[ST_RST_WAKE] <= rstCause_r;
        wb_dat_o[ST_RECOV] <= rec.busy;
      end
    end
  end

  // ----------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------
  // Configuration
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg_r <= CFG_RESET;
    end else if (busWr & isReg(wb_adr_i, CFG_OFS)) begin
      cfg_r <= wb_dat_i[7:0];
    end
  end

  // PLL control; deep entry drops back to crystal clock
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pll_r <= PLL_RESET;
    end else begin
      if (busWr & isReg(wb_adr_i, PLL_OFS)) begin
        pll_r <= wb_dat_i[7:0]; // see (R10)
      end
      if (enterDeep) begin
        pll_r[PLL_BCS] <= 1'b0; // see (R12)
      end
    end
  end

  // Masks and processor interrupt mask bit
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mask_r <= MASK_RESET;
    end else begin
      if (busWr & isReg(wb_adr_i, MASK_OFS)) begin
        mask_r <= wb_dat_i[7:0];
      end
      if (enterStandby | enterDeep) begin
        mask_r[MSK_CPU_I] <= 1'b0; // see (R7) see (R8)
      end
      if (inLowPower & resetWake) begin
        mask_r[MSK_CPU_I] <= 1'b1; // see (R7) see (R8)
      end
    end
  end

  // Break during low power flag, set beats clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      brkFlag_r <= 1'b0;
    end else if (inLowPower & brkWake) begin
      brkFlag_r <= 1'b1; // see (R6)
    end else if (busWr & isReg(wb_adr_i, STAT_OFS) & wb_dat_i[ST_BRK_FLAG]) begin
      brkFlag_r <= 1'b0;
    end
  end

  // Cause of the last wake
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rstCause_r <= 1'b0;
    end else if (inLowPower & (state_nxt != state_r)) begin
      rstCause_r <= resetWake;
    end
  end

  // ----------------------------------------------------------
  // Clock gating outputs
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cpuClkEn <= 1'b1;
      busClkEn <= 1'b1;
    end else begin
      cpuClkEn <= state_nxt == M_RUN; // see (R1) see (R2) see (R9)
      busClkEn <= (state_nxt == M_RUN) | (state_nxt == M_STANDBY) // see (R1)
        | ((state_nxt == M_DEEP) & oscRun); // see (R2)
    end
  end

  // Clock generator outputs
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      oscEnable <= 1'b1;
      pllEnable <= 1'b0;
      genOutputsEn <= 1'b1;
    end else begin
      oscEnable <= ~((state_nxt == M_DEEP) & ~oscRun); // see (R11) see (R13)
      genOutputsEn <= ~((state_nxt == M_DEEP) & ~oscRun); // see (R11)
      pllEnable <= pll_r[PLL_ON] & ((state_nxt == M_RUN) // see (R10)
        | (state_nxt == M_STANDBY)); // see (R13)
    end
  end

  // ----------------------------------------------------------
  // Peripheral control outputs
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      converterRun <= 1'b1;
      periphRun <= 1'b1;
      breakActive <= 1'b0;
      watchdogClkEn <= 1'b1;
      lowVoltActive <= 1'b0;
    end else begin
      converterRun <= (state_nxt == M_RUN) | (state_nxt == M_STANDBY); // see (R3) see (R4)
      periphRun <= (state_nxt == M_RUN) | (state_nxt == M_STANDBY); // see (R20) see (R22)
      breakActive <= brkEn & ((state_nxt == M_RUN) | (state_nxt == M_STANDBY)); // see (R5)
      watchdogClkEn <= (state_nxt == M_RUN) | (state_nxt == M_STANDBY); // see (R14) see (R15)
      lowVoltActive <= lvmEn; // see (R19)
    end
  end

  // One-cycle event pulses
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      converterAbort <= 1'b0;
      watchdogPrescClr <= 1'b0;
      asyncDataBad <= 1'b0;
      syncSerialReset <= 1'b0;
      wakeReq <= 1'b0;
      wakeByReset <= 1'b0;
    end else begin
      converterAbort <= enterDeep; // see (R4)
      watchdogPrescClr <= enterDeep; // see (R15)
      asyncDataBad <= enterDeep & asyncSerialBusy; // see (R20)
      syncSerialReset <= (state_r == M_DEEP) & resetWake; // see (R21)
      wakeReq <= inLowPower & (state_nxt != state_r); // see (R24)
      wakeByReset <= inLowPower & resetWake; // see (R24)
    end
  end

  assign irqMaskBit = mask_r[MSK_CPU_I];
  assign baseClockSelect = pll_r[PLL_BCS];

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // Cycles spent in recovery
  always_ff @(posedge ref_clk) begin
    if (sys_rst || state_r != M_RECOVER) begin
      recCnt_r <= 13'h0000;
    end else begin
      recCnt_r <= recCnt_r + 13'h0001;
    end
  end

  sequence sDeepEntry;
    enterDeep;
  endsequence
  sequence sDeepWake;
    (state_r == M_DEEP) && deepWake && !resetWake;
  endsequence

  a_wait_cpu_off: assert property (enterStandby |=> !cpuClkEn && busClkEn) // see (R1)
    else $error("standby clocks wrong");
  a_deep_bus_off: assert property (sDeepEntry and !oscRun |=> !busClkEn && !cpuClkEn) // see (R2)
    else $error("deep clocks wrong");
  a_conv_abort_pulse: assert property (sDeepEntry |=> converterAbort && !converterRun
    ##1 !converterAbort) // see (R4)
    else $error("converter abort wrong");
  a_break_flag_set: assert property (sDeepWake and breakMatch && brkEn |=> brkFlag_r) // see (R6)
    else $error("break flag not set");
  a_mask_bit_clear: assert property (enterStandby || enterDeep |=> !irqMaskBit) // see (R7)
    else $error("mask bit not cleared");
  a_reset_sets_mask: assert property (inLowPower && resetWake |=> irqMaskBit) // see (R8)
    else $error("mask bit not set by reset");
  a_short_recovery: assert property (sDeepWake and shortRec |-> ##33 !cpuClkEn
    ##1 cpuClkEn) // see (R23)
    else $error("short recovery length wrong");
  a_long_recovery: assert property ($rose(cpuClkEn) && !shortRec
    && $past(state_r) == M_RECOVER |-> recCnt_r >= 13'(RECOV_LONG_CYC)) // see (R23)
    else $error("long recovery too short");
  a_bcs_cleared: assert property (sDeepEntry |=> !baseClockSelect) // see (R12)
    else $error("base clock select kept");
  a_deep_gen_off: assert property (state_r == M_DEEP && !oscRun |->
    !oscEnable && !pllEnable && !genOutputsEn) // see (R11)
    else $error("generator active in deep");
  a_deep_osc_on: assert property (state_r == M_DEEP && oscRun |-> oscEnable && !pllEnable) // see (R13)
    else $error("oscillator run wrong");
  a_stop_refused: assert property (state_r == M_RUN && stopExec && !waitExec && !stopEn
    |=> state_r == M_RUN && cpuClkEn) // see (R16)
    else $error("stop not refused");
  a_deep_watchdog: assert property (sDeepEntry |=> watchdogPrescClr && !watchdogClkEn) // see (R15)
    else $error("watchdog not stopped");
  a_standby_wake: assert property (state_r == M_STANDBY && extWake |=> cpuClkEn
    && wakeReq) // see (R17)
    else $error("standby wake missed");

endmodule // lp_mode_ctrl

//--- tb/core_periph_model.sv
//------------------------------------------------------------
// Purpose: Core and peripheral stand-in for the mode controller
// Assumes: Instructions issue only while the core clock runs
// Notes:   srcOn bits map one to one onto wake lines
//------------------------------------------------------------
`timescale 1ns/1ps
module core_periph_model (
  // Clock
  input wire logic ref_clk,
  // Bench commands
  input wire logic [1:0] instr,
  input wire logic [10:0] srcOn,
  input wire logic cpuClkEn,
  // Toward the controller
  output logic waitExec = 1'b0,
  output logic stopExec = 1'b0,
  output logic [10:0] wake
);
  // A halted core executes nothing
  always_ff @(posedge ref_clk) begin
    waitExec <= cpuClkEn && instr == 2'h1;
    stopExec <= cpuClkEn && instr == 2'h2;
  end
  // Wake lines follow the bench selection
  assign wake = srcOn;
endmodule // core_periph_model

//--- tb/low_power_mode_controller_tb.sv
//------------------------------------------------------------
// Purpose: Self-checking bench for the low-power mode controller
// Assumes: Table rows use short recovery, one long case by hand
// Notes:   Outputs are read at each edge, before that edge updates them
//------------------------------------------------------------
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module low_power_mode_controller_tb import lpm_pkg::*; ;
  typedef struct {logic [1:0] ins; logic [7:0] cfg; int src;} row_t;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00, q;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic waitExec, stopExec, cpuClkEn, busClkEn, irqMaskBit, oscEnable, pllEnable;
  logic converterRun, watchdogClkEn, lowVoltActive, breakActive, wakeReq, wakeByReset;
  logic rw, deep, run;
  logic periphRun, asyncDataBad, syncSerialReset, genOutputsEn, base_clock_select, serBusy = 1'b0;
  int badCnt = 0, srCnt = 0;
  logic [1:0] instr = 2'h0;
  logic [10:0] srcOn = 11'h000, wake;
  int fails = 0, total_checks = 0, n;
  row_t cur;
  // Wait with each wake source but the generator, then stop with external, keypad, break, low-voltage and reset pins
  row_t rows [15] = '{'{2'h1, 8'h00, 2}, '{2'h1, 8'h00, 3}, '{2'h1, 8'h00, 4},
    '{2'h1, 8'h00, 5}, '{2'h1, 8'h20, 7}, '{2'h1, 8'h00, 0}, '{2'h1, 8'h00, 1},
    '{2'h1, 8'h00, 8}, '{2'h1, 8'h18, 9}, '{2'h1, 8'h00, 10}, '{2'h2, 8'h06, 0},
    '{2'h2, 8'h07, 1}, '{2'h2, 8'h26, 7}, '{2'h2, 8'h1E, 9}, '{2'h2, 8'h06, 10}};

  // ----------------------------------------------------------
  // Design and partner
  // ----------------------------------------------------------
  lp_mode_ctrl dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(4'h1), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .waitExec(waitExec),
    .stopExec(stopExec), .cpuClkEn(cpuClkEn), .busClkEn(busClkEn),
    .irqMaskBit(irqMaskBit), .extIrqPin(wake[0]), .kbdIrqPin(wake[1]),
    .converterIrq(wake[2]), .asyncSerialIrq(wake[3]), .syncSerialIrq(wake[4]),
    .timerIrq(wake[5]), .generatorIrq(wake[6]), .breakMatch(wake[7]),
    .watchdogTimeout(wake[8]), .lowVoltPin(wake[9]), .extRstPin(wake[10]),
    .asyncSerialBusy(serBusy), .oscEnable(oscEnable), .pllEnable(pllEnable),
    .genOutputsEn(genOutputsEn), .baseClockSelect(base_clock_select), .converterRun(converterRun),
    .converterAbort(), .breakActive(breakActive), .watchdogClkEn(watchdogClkEn),
    .watchdogPrescClr(), .lowVoltActive(lowVoltActive), .periphRun(periphRun),
    .asyncDataBad(asyncDataBad), .syncSerialReset(syncSerialReset), .wakeReq(wakeReq),
    .wakeByReset(wakeByReset));
  core_periph_model partner (.ref_clk(ref_clk), .instr(instr), .srcOn(srcOn),
    .cpuClkEn(cpuClkEn), .waitExec(waitExec), .stopExec(stopExec), .wake(wake));

  // Count one-cycle pulses that the step checks would miss
  always @(posedge ref_clk) begin
    if (asyncDataBad === 1'b1) badCnt <= badCnt + 1;
    if (syncSerialReset === 1'b1) srCnt <= srCnt + 1;
  end

  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic final_report;
    if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic timeout;
    fails++;
    final_report();
  endtask

  // One classic bus cycle, request held until ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] rd);
    int i;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++) @(posedge ref_clk);
    if (i == 20) timeout();
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Issue an instruction through the core model
  task automatic issue(input logic [1:0] ins);
    instr <= ins;
    @(posedge ref_clk);
    instr <= 2'h0;
    repeat (4) @(posedge ref_clk);
  endtask

  // Wait for the wake pulse, then count edges until the core clock runs
  task automatic wait_wake(output int cnt, output logic byRst);
    int i;
    for (i = 0; i < 200 && wakeReq !== 1'b1; i++) @(posedge ref_clk);
    if (i == 200) timeout();
    byRst = wakeByReset;
    srcOn <= 11'h000;
    for (cnt = 0; cnt < 5000 && cpuClkEn !== 1'b1; cnt++) @(posedge ref_clk);
    if (cnt == 5000) timeout();
  endtask

  // ----------------------------------------------------------
  // Clock and sequence
  // ----------------------------------------------------------
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    wb(1'b0, MASK_OFS, 8'h00, q);
    `CHK("maskReset", MASK_RESET, q)
    wb(1'b0, PLL_OFS, 8'h00, q);
    `CHK("pllReset", PLL_RESET, q)
    // Table of entries and wakes
    foreach (rows[k]) begin
      cur = rows[k];
      wb(1'b1, CFG_OFS, cur.cfg, q);
      wb(1'b1, MASK_OFS, 8'h04, q);
      wb(1'b1, STAT_OFS, 8'h04, q);
      deep = cur.ins == 2'h2;
      run = !deep || cur.cfg[CFG_OSC_RUN];
      serBusy <= deep && cur.src[0];
      issue(cur.ins);
      `CHK("cpuClkEn", 1'b0, cpuClkEn)
      `CHK("busClkEn", run, busClkEn)
      `CHK("irqMaskBit", 1'b0, irqMaskBit)
      `CHK("oscEnable", run, oscEnable)
      `CHK("genOutputsEn", run, genOutputsEn)
      `CHK("pllEnable", 1'b0, pllEnable)
      `CHK("converterRun", !deep, converterRun)
      `CHK("periphRun", !deep, periphRun)
      `CHK("watchdogClkEn", !deep, watchdogClkEn)
      `CHK("lowVoltActive", cur.cfg[CFG_LVM_EN], lowVoltActive)
      `CHK("breakActive", !deep && cur.cfg[CFG_BRK_EN], breakActive)
      srcOn <= 11'h001 << cur.src;
      wait_wake(n, rw);
      `CHK("wakeByReset", cur.src >= 8, rw)
      `CHK("recovery", deep ? 33 : 0, n)
      repeat (6) @(posedge ref_clk);
      `CHK("irqMaskBit", cur.src >= 8, irqMaskBit)
      wb(1'b0, STAT_OFS, 8'h00, q);
      `CHK("status", {4'h0, cur.src >= 8, 3'h0}, q & 8'hFB)
      if (deep && cur.src == 7) `CHK("breakFlag", 1'b1, q[ST_BRK_FLAG])
    end
    // Stop refused while stop enable is clear
    wb(1'b1, CFG_OFS, 8'h00, q);
    issue(2'h2);
    `CHK("cpuClkEn", 1'b1, cpuClkEn)
    // Long recovery, base clock select cleared by deep entry
    wb(1'b1, CFG_OFS, 8'h02, q);
    wb(1'b1, PLL_OFS, 8'h03, q);
    wb(1'b1, MASK_OFS, 8'h04, q);
    `CHK("baseClockSelect", 1'b1, base_clock_select)
    issue(2'h2);
    `CHK("pllEnable", 1'b0, pllEnable)
    srcOn <= 11'h001;
    wait_wake(n, rw);
    `CHK("longRecovery", 4097, n)
    wb(1'b0, PLL_OFS, 8'h00, q);
    `CHK("pllCtrl", 8'h02, q)
    `CHK("baseClockSelect", 1'b0, base_clock_select)
    // Generator request wakes standby once the PLL is powered
    issue(2'h1);
    `CHK("pllEnable", 1'b1, pllEnable)
    srcOn <= 11'h040;
    wait_wake(n, rw);
    `CHK("genWake", 0, n)
    // Reset in mid-run while in standby
    issue(2'h1);
    sys_rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    `CHK("rstCpuClkEn", 1'b1, cpuClkEn)
    `CHK("rstMaskBit", 1'b1, irqMaskBit)
    wb(1'b0, CFG_OFS, 8'h00, q);
    `CHK("cfgReset", CFG_RESET, q)
    // Unmapped place reads zero and ignores writes
    wb(1'b1, 8'h10, 8'hFF, q);
    wb(1'b0, 8'h10, 8'h00, q);
    `CHK("unmapped", 8'h00, q)
    `CHK("asyncDataBad", 3, badCnt)
    `CHK("syncSerialReset", 2, srCnt)
    final_report();
  end
endmodule // low_power_mode_controller_tb
